// ===== bus_grant_pkg.sv
package bus_grant_pkg;

  // ----------------------------------------------------------------
  // widths and map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 14;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned WAIT_W    = 3;
  localparam int unsigned ZONE_CNT  = 3;
  localparam int unsigned ZONE_SEL_W = 2;
  localparam logic [13:0] ROM_ENABLE_WAIT_STATE_CONTROL_ADDR = 14'h3FFE;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned ZONE1_WAIT_FIELD_LSB        = 0;
  localparam int unsigned ZONE2_WAIT_FIELD_LSB        = 3;
  localparam int unsigned ZONE3_WAIT_FIELD_LSB        = 6;
  localparam int unsigned ZONE4_WAIT_FIELD_UNUSED_LSB = 9;
  localparam int unsigned ZONE5_WAIT_FIELD_UNUSED_LSB = 12;
  localparam int unsigned ROM_ENABLE_BIT              = 15;
  localparam logic [15:0] CONTROL_RESET               = 16'h7FFF;
  localparam logic [2:0]  WAIT_RESET                  = 3'h7;

  // ----------------------------------------------------------------
  // states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OWN     = 2'b00,
    ST_ACCESS  = 2'b01,
    ST_GRANTED = 2'b10
  } bus_state_t;

  typedef struct packed {
    bus_state_t        st;
    logic              hang;
    logic [15:0]       ctrl;
    logic [15:0]       rdata;
    logic [13:0]       addr;
    logic              write;
  } arb_state_t;

  typedef struct packed {
    logic       active;
    logic [2:0] cnt;
  } ws_state_t;

endpackage

// ===== zone_wait_gen.sv
`timescale 1ns/100ps
`default_nettype none
module zone_wait_gen (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       start_i,
  input  wire logic [2:0] wait_i,
  output logic            busy_o,
  output logic            last_o
);

  bus_grant_pkg::ws_state_t s_q;
  bus_grant_pkg::ws_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (srst_i) begin
      s_d = '0;
    end else if (!s_q.active && start_i) begin
      s_d.active = 1'b1;
      s_d.cnt    = wait_i;
    end else if (s_q.active) begin
      if (s_q.cnt == 3'h0) begin
        s_d.active = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s_q <= s_d;
  end

  assign busy_o = s_q.active;
  assign last_o = s_q.active && (s_q.cnt == 3'h0);

endmodule
`default_nettype wire

// ===== external_bus_grant_arbiter.sv
// Overview of operation
// - idle bus request grants bus next cycle
// - go mode runs until external access
// - request during access waits until completion
// - grant does not wait for instruction end
// - grant possible between two external accesses
// - request release regains bus and resumes
// - request handling works during reset too
// - hang output when access blocked by grant
// - after bus returns, access then drop hang
// - three zones, each own wait generator
// - all zones seven wait states after reset
// - fourth and fifth zone fields have no effect
// - control register sits at address 0x3FFE
`timescale 1ns/100ps
`default_nettype none
module external_bus_grant_arbiter (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        bus_request_n_i,
  output logic             bus_grant_n_o,
  output logic             grant_hang_n_o,
  output logic             bus_oe_o,
  output logic             data_mem_select_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [13:0]      ext_addr_o,
  input  wire logic        go_mode_i,
  output logic             stall_o,
  input  wire logic        ext_req_i,
  input  wire logic [13:0] ext_addr_i,
  input  wire logic        ext_write_i,
  output logic             ext_done_o,
  input  wire logic [13:0] dm_addr_i,
  input  wire logic        dm_wr_i,
  input  wire logic        dm_rd_i,
  input  wire logic [15:0] dm_wdata_i,
  output logic [15:0]      dm_rdata_o,
  output logic             rom_enable_o
);

  bus_grant_pkg::arb_state_t s_q;
  bus_grant_pkg::arb_state_t s_d;

  logic [bus_grant_pkg::ZONE_CNT-1:0] zone_busy;
  logic [bus_grant_pkg::ZONE_CNT-1:0] zone_last;
  logic [1:0]                         zone_sel;
  logic                               start;
  logic                               ws_last;
  logic                               reg_hit;

  // ----------------------------------------------------------------
  // zone decode and wait generators
  // ----------------------------------------------------------------
  always_comb begin
    if (ext_addr_i[13:12] == 2'h0) begin
      zone_sel = 2'h0;
    end else if (ext_addr_i[13:12] == 2'h1) begin
      zone_sel = 2'h1;
    end else begin
      zone_sel = 2'h2;
    end
  end

  // fields above the third zone never reach a generator
  generate
    for (genvar g = 0; g < bus_grant_pkg::ZONE_CNT; g++) begin : g_zone
      zone_wait_gen u_wait (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .start_i   (start && (zone_sel == 2'(g))),
        .wait_i    (s_q.ctrl[g*bus_grant_pkg::WAIT_W +:
                             bus_grant_pkg::WAIT_W]),
        .busy_o    (zone_busy[g]),
        .last_o    (zone_last[g])
      );
    end
  endgenerate

  assign ws_last = |zone_last;
  assign reg_hit = (dm_addr_i ==
                    bus_grant_pkg::ROM_ENABLE_WAIT_STATE_CONTROL_ADDR);

  // ----------------------------------------------------------------
  // arbiter next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d   = s_q;
    start = 1'b0;
    case (s_q.st)
      bus_grant_pkg::ST_OWN: begin
        if (s_q.hang && ext_req_i) begin
          start = 1'b1;
        end else if (!bus_request_n_i) begin
          s_d.st = bus_grant_pkg::ST_GRANTED;
        end else if (ext_req_i) begin
          start = 1'b1;
        end
      end
      bus_grant_pkg::ST_ACCESS: begin
        if (ws_last) begin
          if (!bus_request_n_i) begin
            s_d.st = bus_grant_pkg::ST_GRANTED;
          end else begin
            s_d.st = bus_grant_pkg::ST_OWN;
          end
          s_d.hang = 1'b0;
        end
      end
      bus_grant_pkg::ST_GRANTED: begin
        if (bus_request_n_i) begin
          s_d.st = bus_grant_pkg::ST_OWN;
        end
        if (ext_req_i) begin
          s_d.hang = 1'b1;
        end
      end
      default: begin
        s_d.st = bus_grant_pkg::ST_OWN;
      end
    endcase
    if (start) begin
      s_d.st    = bus_grant_pkg::ST_ACCESS;
      s_d.addr  = ext_addr_i;
      s_d.write = ext_write_i;
    end
    if (!ext_req_i) begin
      s_d.hang = 1'b0;
    end
    // ---- control register ----
    if (dm_wr_i && reg_hit) begin
      s_d.ctrl = dm_wdata_i;
    end
    if (dm_rd_i && reg_hit) begin
      s_d.rdata = s_q.ctrl;
    end else begin
      s_d.rdata = 16'h0000;
    end
    if (srst_i) begin
      s_d.ctrl  = bus_grant_pkg::CONTROL_RESET;
      s_d.hang  = 1'b0;
      s_d.rdata = 16'h0000;
      s_d.addr  = 14'h0000;
      s_d.write = 1'b0;
      start     = 1'b0;
      if (!bus_request_n_i) begin
        s_d.st = bus_grant_pkg::ST_GRANTED;
      end else begin
        s_d.st = bus_grant_pkg::ST_OWN;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_grant_n_o  = (s_q.st != bus_grant_pkg::ST_GRANTED);
  assign bus_oe_o       = (s_q.st != bus_grant_pkg::ST_GRANTED);
  assign grant_hang_n_o = !s_q.hang;
  assign data_mem_select_n_o = (s_q.st != bus_grant_pkg::ST_ACCESS);
  assign rd_n_o = !((s_q.st == bus_grant_pkg::ST_ACCESS) && !s_q.write);
  assign wr_n_o = !((s_q.st == bus_grant_pkg::ST_ACCESS) && s_q.write);
  assign ext_addr_o   = s_q.addr;
  assign ext_done_o   = (s_q.st == bus_grant_pkg::ST_ACCESS) && ws_last;
  assign dm_rdata_o   = s_q.rdata;
  assign rom_enable_o = s_q.ctrl[bus_grant_pkg::ROM_ENABLE_BIT];
  // without go mode the core halts for the whole grant
  assign stall_o = (s_q.st == bus_grant_pkg::ST_GRANTED) &&
                   (!go_mode_i || ext_req_i);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  AST_GRANT_NEXT: assert property (
    (s_q.st == bus_grant_pkg::ST_OWN && !s_q.hang && !bus_request_n_i)
    |=> (!bus_grant_n_o && !bus_oe_o && data_mem_select_n_o))
    else $error("idle request not granted next cycle");

  AST_GO_MODE: assert property (
    (!bus_grant_n_o && go_mode_i && !ext_req_i) |-> !stall_o)
    else $error("go mode stalled without external access");

  AST_DEFER: assert property (
    (s_q.st == bus_grant_pkg::ST_ACCESS && !ws_last)
    |=> (bus_grant_n_o && bus_oe_o))
    else $error("bus granted during an access");

  AST_ACCESS_LEN: assert property (
    $rose(!data_mem_select_n_o) |-> ##[0:7] ext_done_o)
    else $error("access longer than eight cycles");

  AST_GAP: assert property (
    (ext_done_o && !bus_request_n_i) |=> !bus_grant_n_o)
    else $error("pending request not granted after access");

  AST_RELEASE: assert property (
    (!bus_grant_n_o && bus_request_n_i)
    |=> (bus_grant_n_o && bus_oe_o && !stall_o))
    else $error("grant kept after request release");

  AST_RESET_GRANT: assert property (disable iff (1'b0)
    (srst_i && !bus_request_n_i) |=> !bus_grant_n_o)
    else $error("request ignored during reset");

  AST_HANG: assert property (
    (!bus_grant_n_o && ext_req_i) |=> !grant_hang_n_o)
    else $error("hang not raised while blocked");

  AST_HANG_CLEAR: assert property (
    ext_done_o |=> grant_hang_n_o)
    else $error("hang kept after access done");

  AST_HANG_IDLE: assert property (
    !ext_req_i |=> grant_hang_n_o)
    else $error("hang raised with nothing pending");

  AST_RESET_WAIT: assert property (disable iff (1'b0)
    srst_i |=> (s_q.ctrl == bus_grant_pkg::CONTROL_RESET))
    else $error("control register reset value wrong");

  AST_REG_WRITE: assert property (
    (dm_wr_i && reg_hit) |=> (s_q.ctrl == $past(dm_wdata_i)))
    else $error("control register write lost");

  AST_ZONE_BUSY: assert property (
    $onehot0(zone_busy) && ((|zone_busy) == !data_mem_select_n_o))
    else $error("wait generators out of step with access");

  COV_IDLE_GRANT: cover property (
    bus_request_n_i ##1 !bus_request_n_i ##1 !bus_grant_n_o);
  COV_DEFERRED: cover property (
    (!data_mem_select_n_o && !bus_request_n_i) ##1 !bus_grant_n_o);
  COV_HANG: cover property (!grant_hang_n_o ##[1:20] ext_done_o);
  COV_GO: cover property (!bus_grant_n_o && go_mode_i && !stall_o);

endmodule
`default_nettype wire

// ===== bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input  wire logic ref_clk_i,
  input  wire logic want_i,
  input  wire logic grant_hang_n_i,
  output logic      bus_request_n_o
);
  // ----------------------------------------
  // request driver, backs off on hang
  // ----------------------------------------
  initial begin
    bus_request_n_o = 1'b1;
    forever begin
      @(negedge ref_clk_i);
      bus_request_n_o <= !(want_i && grant_hang_n_i);
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [13:0] CA =
    bus_grant_pkg::ROM_ENABLE_WAIT_STATE_CONTROL_ADDR;
  logic        ref_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        want      = 1'b0;
  logic        go_mode   = 1'b0;
  logic        ext_req   = 1'b0;
  logic        ext_wr    = 1'b0;
  logic [13:0] ext_addr  = 14'h0000;
  logic [13:0] dm_addr   = 14'h0000;
  logic        dm_wr     = 1'b0;
  logic        dm_rd     = 1'b0;
  logic [15:0] dm_wdata  = 16'h0000;
  logic [15:0] dm_rdata;
  logic        req_n, grant_n, hang_n, bus_oe, sel_n, rd_n, wr_n;
  logic        stall, done, rom_en;
  logic [13:0] xaddr;
  int          num_errors = 0;
  int          checks     = 0;
  int          cycles     = 0;
  int          n;

  always #50 ref_clk_i = ~ref_clk_i;

  bus_master_model PEER (
    .ref_clk_i      (ref_clk_i),
    .want_i         (want),
    .grant_hang_n_i (hang_n),
    .bus_request_n_o(req_n)
  );

  external_bus_grant_arbiter DUT (
    .ref_clk_i          (ref_clk_i),
    .srst_i             (srst_i),
    .bus_request_n_i    (req_n),
    .bus_grant_n_o      (grant_n),
    .grant_hang_n_o     (hang_n),
    .bus_oe_o           (bus_oe),
    .data_mem_select_n_o(sel_n),
    .rd_n_o             (rd_n),
    .wr_n_o             (wr_n),
    .ext_addr_o         (xaddr),
    .go_mode_i          (go_mode),
    .stall_o            (stall),
    .ext_req_i          (ext_req),
    .ext_addr_i         (ext_addr),
    .ext_write_i        (ext_wr),
    .ext_done_o         (done),
    .dm_addr_i          (dm_addr),
    .dm_wr_i            (dm_wr),
    .dm_rd_i            (dm_rd),
    .dm_wdata_i         (dm_wdata),
    .dm_rdata_o         (dm_rdata),
    .rom_enable_o       (rom_en)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task wait_done(output int k);
    k = 0;
    do begin
      @(negedge ref_clk_i);
      k++;
    end while (done !== 1'b1 && k < 20);
  endtask

  task access(input logic [13:0] a, input logic w, input int exp_n);
    int k;
    @(negedge ref_clk_i);
    ext_addr = a;
    ext_wr = w;
    ext_req = 1'b1;
    wait_done(k);
    chk(16'(k), 16'(exp_n));
    chk(16'(xaddr), 16'(a));
    chk(16'(w ? wr_n : rd_n), 16'h0000);
    chk(16'(sel_n), 16'h0000);
    ext_req = 1'b0;
  endtask

  task wr(input logic [15:0] d);
    @(negedge ref_clk_i);
    dm_addr = CA;
    dm_wdata = d;
    dm_wr = 1'b1;
    @(negedge ref_clk_i);
    dm_wr = 1'b0;
  endtask

  task rd(input logic [13:0] a, input logic [15:0] exp);
    @(negedge ref_clk_i);
    dm_addr = a;
    dm_rd = 1'b1;
    @(negedge ref_clk_i);
    dm_rd = 1'b0;
    chk(dm_rdata, exp);
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge ref_clk_i);
    want <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk(16'(grant_n), 16'h0000);
    want <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk(16'(grant_n), 16'h0001);
    repeat (5) @(negedge ref_clk_i);
    srst_i = 1'b0;
    rd(CA, 16'h7FFF);
    rd(14'h3FFD, 16'h0000);
    chk(16'(rom_en), 16'h0000);
    access(14'h0000, 1'b0, 8);
    wr(16'hF3D0);
    rd(CA, 16'hF3D0);
    chk(16'(rom_en), 16'h0001);
    access(14'h0004, 1'b1, 1);
    access(14'h1000, 1'b0, 3);
    access(14'h2000, 1'b1, 8);
    @(negedge ref_clk_i);
    want <= 1'b1;
    @(negedge ref_clk_i);
    chk(16'(grant_n), 16'h0001);
    @(negedge ref_clk_i);
    chk({14'h0, grant_n, bus_oe}, 16'h0000);
    chk({13'h0, sel_n, rd_n, wr_n}, 16'h0007);
    chk(16'(stall), 16'h0001);
    go_mode = 1'b1;
    #1 chk(16'(stall), 16'h0000);
    want <= 1'b0;
    @(negedge ref_clk_i);
    chk(16'(grant_n), 16'h0000);
    @(negedge ref_clk_i);
    chk({14'h0, grant_n, bus_oe}, 16'h0003);
    @(negedge ref_clk_i);
    ext_addr = 14'h2000;
    ext_wr = 1'b0;
    ext_req = 1'b1;
    want <= 1'b1;
    wait_done(n);
    chk(16'(n), 16'h0008);
    chk(16'(grant_n), 16'h0001);
    ext_addr = 14'h0000;
    @(negedge ref_clk_i);
    chk({14'h0, grant_n, bus_oe}, 16'h0000);
    chk(16'(stall), 16'h0001);
    @(negedge ref_clk_i);
    chk(16'(hang_n), 16'h0000);
    wait_done(n);
    chk({14'h0, bus_oe, hang_n}, 16'h0002);
    ext_req = 1'b0;
    want <= 1'b0;
    @(negedge ref_clk_i);
    chk(16'(hang_n), 16'h0001);
    results;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      results;
    end
  end
endmodule
`default_nettype wire
